// File: hdl/pasb_pkg.sv
// Shared constants for the power aware split bridge.
// Assumes both halves are compiled against this package.
package pasb_pkg;
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 32;
  localparam int CNT_W    = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic        TGL_RESET = 1'b0;
endpackage : pasb_pkg

// File: hdl/pasb_xing_if.sv
// Crossing signals between the two bridge halves.
// Each toggle marks one word; its data stays still until answered.
`timescale 1ns/100ps
interface pasb_xing_if;
  logic                        req_tgl;
  logic                        req_write;
  logic [pasb_pkg::ADDR_W-1:0] req_addr;
  logic [pasb_pkg::DATA_W-1:0] req_wdata;
  logic                        rsp_tgl;
  logic                        rsp_error;
  logic [pasb_pkg::DATA_W-1:0] rsp_rdata;

  modport up (
    output req_tgl, req_write, req_addr, req_wdata,
    input  rsp_tgl, rsp_error, rsp_rdata
  );
  modport down (
    input  req_tgl, req_write, req_addr, req_wdata,
    output rsp_tgl, rsp_error, rsp_rdata
  );
endinterface : pasb_xing_if

// File: hdl/pasb_down_half.sv
// Downstream half of the bridge: drives the target on its own clock.
// Assumes the upstream half holds request data stable while a word is open.
`timescale 1ns/100ps
module pasb_down_half (
  // Downstream clock domain
  input  wire logic                        down_clock,
  input  wire logic                        down_rst,
  // Crossing
  pasb_xing_if.down                        xing,
  // Target side
  output logic                             dn_req_valid,
  input  wire logic                        dn_req_ready,
  output logic                             dn_req_write,
  output logic [pasb_pkg::ADDR_W-1:0]      dn_req_addr,
  output logic [pasb_pkg::DATA_W-1:0]      dn_req_wdata,
  input  wire logic                        dn_rsp_valid,
  output logic                             dn_rsp_ready,
  input  wire logic                        dn_rsp_error,
  input  wire logic [pasb_pkg::DATA_W-1:0] dn_rsp_rdata
);
  typedef enum logic [1:0] {MD_IDLE, MD_REQ, MD_RSP} pasb_md_t;

  ////////////////////////////////////////////////////////////////////////
  logic [2:0]               sync_reg, sync_next;
  logic                     seen_reg, seen_next;
  pasb_md_t                 st_reg, st_next;
  logic                     tgl_reg, tgl_next;
  logic                     err_reg, err_next;
  logic [pasb_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic                     req_event;

  // Receiving part of the request synchroniser
  assign req_event = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != seen_reg);

  always_comb begin
    sync_next  = {sync_reg[1:0], xing.req_tgl};
    seen_next  = seen_reg;
    st_next    = st_reg;
    tgl_next   = tgl_reg;
    err_next   = err_reg;
    rdata_next = rdata_reg;
    case (st_reg)
      MD_IDLE: begin
        if (req_event) begin
          seen_next = sync_reg[2];
          st_next   = MD_REQ;
        end
      end
      MD_REQ: begin
        if (dn_req_ready) begin
          st_next = MD_RSP;
        end
      end
      MD_RSP: begin
        if (dn_rsp_valid) begin
          err_next   = dn_rsp_error;
          rdata_next = dn_rsp_rdata;
          tgl_next   = ~tgl_reg;
          st_next    = MD_IDLE;
        end
      end
      default: st_next = MD_IDLE;
    endcase
  end

  // Own reset only; synchroniser keeps running and both toggles take the
  // far request toggle, so no stale word or answer fires after reset
  always_ff @(posedge down_clock) begin
    if (down_rst) begin
      sync_reg  <= sync_next;
      seen_reg  <= sync_reg[2];
      st_reg    <= MD_IDLE;
      tgl_reg   <= sync_reg[2];
      err_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      sync_reg  <= sync_next;
      seen_reg  <= seen_next;
      st_reg    <= st_next;
      tgl_reg   <= tgl_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign dn_req_valid   = (st_reg == MD_REQ);
  assign dn_rsp_ready   = (st_reg == MD_RSP);
  assign dn_req_write   = xing.req_write;
  assign dn_req_addr    = xing.req_addr;
  assign dn_req_wdata   = xing.req_wdata;
  assign xing.rsp_tgl   = tgl_reg;
  assign xing.rsp_error = err_reg;
  assign xing.rsp_rdata = rdata_reg;
endmodule : pasb_down_half

// File: hdl/pasb_bridge.sv
// Power aware split bridge top: upstream half, drain logic, downstream half.
// Assumes the power controller holds its request until it sees acknowledge.
`timescale 1ns/100ps
module pasb_bridge (
  // Upstream clock domain
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Downstream clock domain
  input  wire logic                        down_clock,
  input  wire logic                        down_rst,
  // Initiator side
  input  wire logic                        up_req_valid,
  output logic                             up_req_ready,
  input  wire logic                        up_req_write,
  input  wire logic [pasb_pkg::ADDR_W-1:0] up_req_addr,
  input  wire logic [pasb_pkg::DATA_W-1:0] up_req_wdata,
  output logic                             up_rsp_valid,
  input  wire logic                        up_rsp_ready,
  output logic                             up_rsp_error,
  output logic [pasb_pkg::DATA_W-1:0]      up_rsp_rdata,
  // Target side
  output logic                             dn_req_valid,
  input  wire logic                        dn_req_ready,
  output logic                             dn_req_write,
  output logic [pasb_pkg::ADDR_W-1:0]      dn_req_addr,
  output logic [pasb_pkg::DATA_W-1:0]      dn_req_wdata,
  input  wire logic                        dn_rsp_valid,
  output logic                             dn_rsp_ready,
  input  wire logic                        dn_rsp_error,
  input  wire logic [pasb_pkg::DATA_W-1:0] dn_rsp_rdata,
  // Power controller handshake
  input  wire logic                        power_controller_req,
  output logic                             power_controller_ack,
  output logic [pasb_pkg::CNT_W-1:0]       open_count
);
  typedef enum logic [1:0] {SL_IDLE, SL_WAIT, SL_RESP} pasb_sl_t;

  pasb_xing_if xing ();

  ////////////////////////////////////////////////////////////////////////
  // Upstream half state
  logic [2:0]                  pd_sync_reg, pd_sync_next;
  logic                        pend_reg, pend_next;
  logic [2:0]                  rs_sync_reg, rs_sync_next;
  logic                        rs_seen_reg, rs_seen_next;
  pasb_sl_t                    st_reg, st_next;
  logic                        tgl_reg, tgl_next;
  logic                        wr_reg, wr_next;
  logic [pasb_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [pasb_pkg::DATA_W-1:0] wdata_reg, wdata_next;
  logic                        rv_reg, rv_next;
  logic                        re_reg, re_next;
  logic [pasb_pkg::DATA_W-1:0] rd_reg, rd_next;
  logic                        fwd_reg, fwd_next;
  logic [pasb_pkg::CNT_W-1:0]  cnt_reg, cnt_next;
  logic                        ack_reg, ack_next;
  logic                        pd_level;
  logic                        pd_stable;
  logic                        rsp_event;
  logic                        take;

  // Power request is a pin level: change counts once stages two and three agree
  assign pd_stable = (pd_sync_reg[1] == pd_sync_reg[2]);
  assign pd_level  = pd_sync_reg[2];
  // Sending part's answer receiver
  assign rsp_event = (rs_sync_reg[1] == rs_sync_reg[2])
                  && (rs_sync_reg[2] != rs_seen_reg);
  // One word in flight keeps the crossing data still without a buffer
  assign take = up_req_valid && up_req_ready;

  always_comb begin
    pd_sync_next = {pd_sync_reg[1:0], power_controller_req};
    rs_sync_next = {rs_sync_reg[1:0], xing.rsp_tgl};
    pend_next    = pend_reg;
    rs_seen_next = rs_seen_reg;
    st_next      = st_reg;
    tgl_next     = tgl_reg;
    wr_next      = wr_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    rv_next      = rv_reg;
    re_next      = re_reg;
    rd_next      = rd_reg;
    fwd_next     = fwd_reg;
    cnt_next     = cnt_reg;
    if (pd_stable) begin
      pend_next = pd_level;
    end
    case (st_reg)
      SL_IDLE: begin
        if (take && pend_reg) begin
          rv_next  = 1'b1;
          re_next  = 1'b1;
          rd_next  = '0;
          fwd_next = 1'b0;
          st_next  = SL_RESP;
        end else if (take) begin
          wr_next    = up_req_write;
          addr_next  = up_req_addr;
          wdata_next = up_req_wdata;
          tgl_next   = ~tgl_reg;
          fwd_next   = 1'b1;
          cnt_next   = cnt_reg + pasb_pkg::CNT_ONE;
          st_next    = SL_WAIT;
        end
      end
      SL_WAIT: begin
        // Open word runs to completion even if power-down arrived
        if (rsp_event) begin
          rs_seen_next = rs_sync_reg[2];
          rv_next      = 1'b1;
          re_next      = xing.rsp_error;
          rd_next      = xing.rsp_rdata;
          st_next      = SL_RESP;
        end
      end
      SL_RESP: begin
        if (up_rsp_ready) begin
          rv_next = 1'b0;
          if (fwd_reg) begin
            cnt_next = cnt_reg - pasb_pkg::CNT_ONE;
          end
          fwd_next = 1'b0;
          st_next  = SL_IDLE;
        end
      end
      default: st_next = SL_IDLE;
    endcase
    // Drained only with nothing open and the crossing quiet
    ack_next = pend_next && (cnt_next == pasb_pkg::CNT_ZERO)
            && (st_next != SL_WAIT);
  end

  // Own reset only; answer synchroniser keeps running and both toggles
  // take the far answer toggle, so the far half sees no phantom word
  always_ff @(posedge clock) begin
    if (rst) begin
      pd_sync_reg <= 3'h0;
      pend_reg    <= 1'b0;
      rs_sync_reg <= rs_sync_next;
      rs_seen_reg <= rs_sync_reg[2];
      st_reg      <= SL_IDLE;
      tgl_reg     <= rs_sync_reg[2];
      wr_reg      <= 1'b0;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      rv_reg      <= 1'b0;
      re_reg      <= 1'b0;
      rd_reg      <= '0;
      fwd_reg     <= 1'b0;
      cnt_reg     <= pasb_pkg::CNT_ZERO;
      ack_reg     <= 1'b0;
    end else begin
      pd_sync_reg <= pd_sync_next;
      pend_reg    <= pend_next;
      rs_sync_reg <= rs_sync_next;
      rs_seen_reg <= rs_seen_next;
      st_reg      <= st_next;
      tgl_reg     <= tgl_next;
      wr_reg      <= wr_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      rv_reg      <= rv_next;
      re_reg      <= re_next;
      rd_reg      <= rd_next;
      fwd_reg     <= fwd_next;
      cnt_reg     <= cnt_next;
      ack_reg     <= ack_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign up_req_ready         = (st_reg == SL_IDLE);
  assign up_rsp_valid         = rv_reg;
  assign up_rsp_error         = re_reg;
  assign up_rsp_rdata         = rd_reg;
  assign power_controller_ack = ack_reg;
  assign open_count           = cnt_reg;
  assign xing.req_tgl         = tgl_reg;
  assign xing.req_write       = wr_reg;
  assign xing.req_addr        = addr_reg;
  assign xing.req_wdata       = wdata_reg;

  // Downstream half on its own clock and reset
  pasb_down_half u_down (
    .down_clock   (down_clock),
    .down_rst     (down_rst),
    .xing         (xing.down),
    .dn_req_valid (dn_req_valid),
    .dn_req_ready (dn_req_ready),
    .dn_req_write (dn_req_write),
    .dn_req_addr  (dn_req_addr),
    .dn_req_wdata (dn_req_wdata),
    .dn_rsp_valid (dn_rsp_valid),
    .dn_rsp_ready (dn_rsp_ready),
    .dn_rsp_error (dn_rsp_error),
    .dn_rsp_rdata (dn_rsp_rdata)
  );
endmodule : pasb_bridge

// File: verif/pasb_bridge_props.sv
// Checker for the power aware split bridge, bound to pasb_bridge.
// Assumes it sees only the top ports; drain and ack are upstream-domain.
`timescale 1ns/100ps
module pasb_bridge_props (
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic                        down_clock,
  input wire logic                        down_rst,
  input wire logic                        up_req_valid,
  input wire logic                        up_req_ready,
  input wire logic                        up_rsp_valid,
  input wire logic                        up_rsp_ready,
  input wire logic                        up_rsp_error,
  input wire logic [pasb_pkg::DATA_W-1:0] up_rsp_rdata,
  input wire logic                        dn_req_valid,
  input wire logic                        dn_req_ready,
  input wire logic [pasb_pkg::ADDR_W-1:0] dn_req_addr,
  input wire logic                        power_controller_req,
  input wire logic                        power_controller_ack,
  input wire logic [pasb_pkg::CNT_W-1:0]  open_count
);
  ack_idle_a: assert property (@(posedge clock) disable iff (rst)
    power_controller_ack |-> open_count == pasb_pkg::CNT_ZERO)
    else $error("ack high with open transactions");
  ack_rise_a: assert property (@(posedge clock) disable iff (rst)
    (power_controller_req && up_req_ready && !up_rsp_valid) [*8]
    |-> power_controller_ack) else $error("ack missing when idle");
  ack_hold_a: assert property (@(posedge clock) disable iff (rst)
    power_controller_ack && power_controller_req |=> power_controller_ack)
    else $error("ack dropped while request held");
  ack_drop_a: assert property (@(posedge clock) disable iff (rst)
    $fell(power_controller_req) |-> ##[1:8] !power_controller_ack)
    else $error("ack stuck after request withdrawn");
  reject_fast_a: assert property (@(posedge clock) disable iff (rst)
    power_controller_ack && up_req_valid && up_req_ready |=> up_rsp_valid
    && up_rsp_error && open_count == pasb_pkg::CNT_ZERO)
    else $error("new request not rejected");
  count_inc_a: assert property (@(posedge clock) disable iff (rst)
    up_req_valid && up_req_ready && !power_controller_ack ##1 !up_rsp_valid
    |-> open_count == pasb_pkg::CNT_ONE) else $error("count not raised");
  count_dec_a: assert property (@(posedge clock) disable iff (rst)
    up_rsp_valid && up_rsp_ready |=> open_count == pasb_pkg::CNT_ZERO)
    else $error("count not lowered");
  rsp_hold_a: assert property (@(posedge clock) disable iff (rst)
    up_rsp_valid && !up_rsp_ready |=> up_rsp_valid && $stable(up_rsp_error)
    && $stable(up_rsp_rdata)) else $error("answer changed before taken");
  dn_hold_a: assert property (@(posedge down_clock) disable iff (down_rst)
    dn_req_valid && !dn_req_ready |=> dn_req_valid
    && $stable(dn_req_addr)) else $error("target request not held");
endmodule : pasb_bridge_props
bind pasb_bridge pasb_bridge_props u_props (.*);

// File: verif/pasb_target_model.sv
// Behavioural target on the downstream side of the bridge.
// Assumes the bridge holds its request until ready is seen.
`timescale 1ns/100ps
module pasb_target_model (
  input  wire logic                        down_clock,
  input  wire logic                        down_rst,
  input  wire logic [7:0]                  delay,
  input  wire logic                        dn_req_valid,
  output logic                             dn_req_ready,
  input  wire logic [pasb_pkg::ADDR_W-1:0] dn_req_addr,
  input  wire logic                        dn_rsp_ready,
  output logic                             dn_rsp_valid,
  output logic                             dn_rsp_error,
  output logic [pasb_pkg::DATA_W-1:0]      dn_rsp_rdata,
  output int                               fwd_count
);
  logic [pasb_pkg::ADDR_W-1:0] addr;
  initial begin
    dn_req_ready = 1'b0;
    dn_rsp_valid = 1'b0;
    dn_rsp_error = 1'b0;
    dn_rsp_rdata = 32'h0000_0000;
    fwd_count    = 0;
    forever begin
      @(posedge down_clock);
      if (!down_rst && dn_req_valid) begin
        repeat (delay) @(posedge down_clock);
        #1 dn_req_ready = 1'b1;
        @(posedge down_clock);
        addr = dn_req_addr;
        fwd_count++;
        #1 dn_req_ready = 1'b0;
        repeat (delay) @(posedge down_clock);
        #1 dn_rsp_valid = 1'b1;
        dn_rsp_rdata = ~addr;
        do @(posedge down_clock); while (!dn_rsp_ready);
        // Released data flips so a stale capture cannot look right
        #1 dn_rsp_valid = 1'b0;
        dn_rsp_rdata = addr;
      end
    end
  end
endmodule : pasb_target_model

// File: verif/tb_power_aware_split_bridge.sv
// Self-checking bench for pasb_bridge with a behavioural target.
// Assumes the bridge handles one outstanding request at a time.
`timescale 1ns/100ps
module tb_power_aware_split_bridge;
  logic clock = 1'b0, rst = 1'b1, down_clock = 1'b0, down_rst = 1'b1;
  logic up_req_valid = 1'b0, up_req_ready, up_req_write = 1'b0;
  logic [31:0] up_req_addr = 32'h0000_0000, up_req_wdata = 32'h0000_0000;
  logic up_rsp_valid, up_rsp_ready = 1'b0, up_rsp_error;
  logic [31:0] up_rsp_rdata, dn_req_addr, dn_req_wdata, dn_rsp_rdata;
  logic dn_req_valid, dn_req_ready, dn_req_write, dn_rsp_valid;
  logic dn_rsp_ready, dn_rsp_error, pc_req = 1'b0, pc_ack;
  logic [7:0] delay = 8'h02;
  logic [3:0] open_count;
  int errors = 0, tests_run = 0, fwd;
  logic err;
  logic [31:0] rd;
  logic cap_wr = 1'b0;
  logic [31:0] cap_wdata = 32'h0000_0000;
  // Payload seen by the target when it accepts a request
  always @(posedge down_clock) begin
    if (dn_req_valid && dn_req_ready) begin
      cap_wr    <= dn_req_write;
      cap_wdata <= dn_req_wdata;
    end
  end
  always #4 clock = ~clock;
  always #6.5 down_clock = ~down_clock;
  pasb_bridge dut (.clock(clock), .rst(rst), .down_clock(down_clock),
    .down_rst(down_rst), .up_req_valid(up_req_valid),
    .up_req_ready(up_req_ready), .up_req_write(up_req_write),
    .up_req_addr(up_req_addr), .up_req_wdata(up_req_wdata),
    .up_rsp_valid(up_rsp_valid), .up_rsp_ready(up_rsp_ready),
    .up_rsp_error(up_rsp_error), .up_rsp_rdata(up_rsp_rdata),
    .dn_req_valid(dn_req_valid), .dn_req_ready(dn_req_ready),
    .dn_req_write(dn_req_write), .dn_req_addr(dn_req_addr),
    .dn_req_wdata(dn_req_wdata), .dn_rsp_valid(dn_rsp_valid),
    .dn_rsp_ready(dn_rsp_ready), .dn_rsp_error(dn_rsp_error),
    .dn_rsp_rdata(dn_rsp_rdata), .power_controller_req(pc_req),
    .power_controller_ack(pc_ack), .open_count(open_count));
  pasb_target_model target (.down_clock(down_clock), .down_rst(down_rst),
    .delay(delay), .dn_req_valid(dn_req_valid), .dn_req_ready(dn_req_ready),
    .dn_req_addr(dn_req_addr), .dn_rsp_ready(dn_rsp_ready),
    .dn_rsp_valid(dn_rsp_valid), .dn_rsp_error(dn_rsp_error),
    .dn_rsp_rdata(dn_rsp_rdata), .fwd_count(fwd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_for(ref logic sig, input logic lvl);
    for (int i = 0; sig !== lvl; i++) begin
      if (i > 3000) begin
        errors++;
        $display("wait bound used up");
        finish_test();
      end
      @(posedge clock);
      #1;
    end
  endtask : wait_for
  // One request, answer held two cycles before it is taken
  task automatic do_req(input logic [31:0] a, output logic e,
                        output logic [31:0] d);
    up_req_valid = 1'b1;
    up_req_addr  = a;
    @(posedge clock);
    while (!up_req_ready) @(posedge clock);
    #1 up_req_valid = 1'b0;
    up_req_addr = ~a;
    wait_for(up_rsp_valid, 1'b1);
    repeat (2) @(posedge clock);
    #1 e = up_rsp_error;
    d = up_rsp_rdata;
    up_rsp_ready = 1'b1;
    @(posedge clock);
    #1 up_rsp_ready = 1'b0;
  endtask : do_req
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_forward;
    int f0 = fwd;
    up_req_write = 1'b1;
    up_req_wdata = 32'hC3C3_0F0F;
    do_req(32'h1234_5678, err, rd);
    up_req_write = 1'b0;
    up_req_wdata = 32'h0000_0000;
    check("fwd write", {31'h0, cap_wr}, 32'h0000_0001);
    check("fwd wdata", cap_wdata, 32'hC3C3_0F0F);
    check("fwd error", {31'h0, err}, 32'h0000_0000);
    check("fwd rdata", rd, 32'hEDCB_A987);
    check("fwd count", fwd - f0, 32'h0000_0001);
    $display("forward test done");
  endtask : t_forward
  task automatic t_idle_shutdown;
    int f0 = fwd;
    pc_req = 1'b1;
    wait_for(pc_ack, 1'b1);
    do_req(32'h0000_0040, err, rd);
    check("reject error", {31'h0, err}, 32'h0000_0001);
    check("reject rdata", rd, 32'h0000_0000);
    check("reject fwd", fwd - f0, 32'h0000_0000);
    check("ack held", {31'h0, pc_ack}, 32'h0000_0001);
    pc_req = 1'b0;
    wait_for(pc_ack, 1'b0);
    do_req(32'h0000_0044, err, rd);
    check("resume error", {31'h0, err}, 32'h0000_0000);
    check("resume fwd", fwd - f0, 32'h0000_0001);
    $display("idle shutdown test done");
  endtask : t_idle_shutdown
  task automatic t_drain;
    delay = 8'h14;
    fork
      do_req(32'hA5A5_0000, err, rd);
      begin
        repeat (4) @(posedge clock);
        #1 pc_req = 1'b1;
        repeat (20) @(posedge clock);
        #1 check("ack early", {31'h0, pc_ack}, 32'h0000_0000);
      end
    join
    check("drain error", {31'h0, err}, 32'h0000_0000);
    check("drain rdata", rd, 32'h5A5A_FFFF);
    wait_for(pc_ack, 1'b1);
    pc_req = 1'b0;
    wait_for(pc_ack, 1'b0);
    delay = 8'h00;
    $display("drain test done");
  endtask : t_drain
  // Each half reset alone, downstream with the toggles at one, upstream with them back at zero; no stale word may pass
  task automatic t_reset;
    @(posedge down_clock);
    #1 down_rst = 1'b1;
    repeat (6) @(posedge down_clock);
    #1 down_rst = 1'b0;
    t_forward();
    @(posedge clock);
    #1 rst = 1'b1;
    repeat (6) @(posedge clock);
    #1 check("reset count", {28'h0, open_count}, 32'h0000_0000);
    check("reset ack", {31'h0, pc_ack}, 32'h0000_0000);
    check("reset rsp", {31'h0, up_rsp_valid}, 32'h0000_0000);
    rst = 1'b0;
    t_forward();
    $display("reset test done");
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    down_rst = 1'b0;
    t_forward();
    t_reset();
    t_idle_shutdown();
    t_drain();
    t_forward();
    finish_test();
  end
endmodule : tb_power_aware_split_bridge
